// ===== rtl/mif_pkg.sv
// Package for the MAC interrupt flag and control block.
// Assumes one 250 MHz clock and a word-aligned Avalon-MM slave bus.
package mif_pkg;

  // Byte offsets of the registers
  localparam logic [3:0] OFS_TFC  = 4'h0;
  localparam logic [3:0] OFS_EXT  = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;

  // Test and features control bit positions
  localparam int TFC_AUTO_PAD  = 11;
  localparam int TFC_USER_CMD  = 7;
  localparam int TFC_USER_FLAG = 6;
  localparam int TFC_RCO_FLAG  = 5;
  localparam int TFC_RCO_MASK  = 4;
  localparam int TFC_TXB_FLAG  = 3;
  localparam int TFC_TXB_MASK  = 2;

  // Extended control bit positions
  localparam int EXT_TOK_DIS = 15;
  localparam int EXT_LT_EN   = 14;

  // Main control bit positions
  localparam int CTRL_GLB_EN  = 0;
  localparam int CTRL_STOP    = 1;
  localparam int CTRL_SW_RST  = 2;
  localparam int CTRL_TX_DONE = 3;
  localparam int CTRL_SUMMARY = 4;

  // Transmit descriptor word one bit positions
  localparam int DESC_PER_FRAME_IRQ = 28;
  localparam int DESC_APPEND_FCS    = 29;

  // Reset values
  localparam logic RST_MASK  = 1'b1;
  localparam logic RST_CLEAR = 1'b0;

  // Flag indices
  localparam int FLAG_N    = 4;
  localparam int FLAG_USER = 0;
  localparam int FLAG_RCO  = 1;
  localparam int FLAG_TXB  = 2;
  localparam int FLAG_TXD  = 3;

  // Shortest frame before padding, in bytes
  localparam logic [10:0] MIN_FRAME_BYTES = 11'd64;

  typedef struct packed {
    logic        begin_pulse;
    logic        done_pulse;
    logic        done_ok;
    logic        disable_transmit_checksum;
    logic [10:0] frame_bytes;
    logic [31:0] transmit_descriptor_word_one;
  } mif_tx_event_t;

endpackage : mif_pkg

// ===== rtl/mif_flag_cell.sv
// One sticky flag: hardware set, host write-one clear, stop clear.
// Assumes synchronous active-low reset on the block clock.
module mif_flag_cell
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic set_in,
  input  wire logic clear_in,
  input  wire logic kill_in,
  output logic      flag_out
);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      flag_out <= mif_pkg::RST_CLEAR;
    else if (set_in)
      flag_out <= 1'b1; // Event wins over a clear in the same cycle
    else if (clear_in || kill_in)
      flag_out <= 1'b0;
  end

endmodule : mif_flag_cell

// ===== rtl/mif_top.sv
// Interrupt flags, masks and transmit qualifiers of a MAC, Avalon slave.
// Assumes tx and collision events are one-cycle pulses on clk_in.
module mif_top
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic [3:0]             avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output logic [31:0]                 avs_readdata_out,
  output logic                        avs_waitrequest_out,
  input  wire logic                   rx_coll_wrap_in,
  input  wire mif_pkg::mif_tx_event_t tx_event_in,
  output logic                        tx_pad_out,
  output logic                        tx_append_fcs_out,
  output logic                        irq_output_pin_out,
  output logic                        irq_summary_out
);

  logic                       auto_pad_reg;
  logic                       user_cmd_reg;
  logic                       rco_mask_reg;
  logic                       txb_mask_reg;
  logic                       tok_dis_reg;
  logic                       lt_en_reg;
  logic                       glb_en_reg;
  logic                       stop_reg;
  logic                       srst_reg;
  logic                       user_set_reg;
  logic [mif_pkg::FLAG_N-1:0] flags;
  logic [mif_pkg::FLAG_N-1:0] flag_set;
  logic [mif_pkg::FLAG_N-1:0] flag_clr;
  logic [mif_pkg::FLAG_N-1:0] flag_kill;
  logic [31:0]                be_mask;
  logic [31:0]                wbits;
  logic [31:0]                rdata_next;
  logic                       wr_go;
  logic                       wr_tfc;
  logic                       wr_ext;
  logic                       wr_ctrl;
  logic                       soft_kill;
  logic                       done_set;
  logic                       summary_next;
  logic                       short_frame;

  // Bus handshake: one wait cycle, then a one-cycle answer
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) &&
                               avs_waitrequest_out);
  end

  assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wbits   = avs_writedata_in & be_mask;
  assign wr_go   = avs_write_in && !avs_waitrequest_out;

  // Address decode; unmapped writes are dropped, reads return zero
  always_comb
  begin
    wr_tfc  = 1'b0;
    wr_ext  = 1'b0;
    wr_ctrl = 1'b0;
    if (avs_address_in == mif_pkg::OFS_TFC)
      wr_tfc = wr_go;
    else if (avs_address_in == mif_pkg::OFS_EXT)
      wr_ext = wr_go;
    else if (avs_address_in == mif_pkg::OFS_CTRL)
      wr_ctrl = wr_go;
  end

  always_comb
  begin
    rdata_next = 32'h0000_0000; // Reserved bits read as zero
    if (avs_address_in == mif_pkg::OFS_TFC)
    begin
      rdata_next[mif_pkg::TFC_AUTO_PAD]  = auto_pad_reg;
      rdata_next[mif_pkg::TFC_USER_CMD]  = user_cmd_reg;
      rdata_next[mif_pkg::TFC_USER_FLAG] = flags[mif_pkg::FLAG_USER];
      rdata_next[mif_pkg::TFC_RCO_FLAG]  = flags[mif_pkg::FLAG_RCO];
      rdata_next[mif_pkg::TFC_RCO_MASK]  = rco_mask_reg;
      rdata_next[mif_pkg::TFC_TXB_FLAG]  = flags[mif_pkg::FLAG_TXB];
      rdata_next[mif_pkg::TFC_TXB_MASK]  = txb_mask_reg;
    end
    else if (avs_address_in == mif_pkg::OFS_EXT)
    begin
      rdata_next[mif_pkg::EXT_TOK_DIS] = tok_dis_reg;
      rdata_next[mif_pkg::EXT_LT_EN]   = lt_en_reg;
    end
    else if (avs_address_in == mif_pkg::OFS_CTRL)
    begin
      rdata_next[mif_pkg::CTRL_GLB_EN]  = glb_en_reg;
      rdata_next[mif_pkg::CTRL_TX_DONE] = flags[mif_pkg::FLAG_TXD];
      rdata_next[mif_pkg::CTRL_SUMMARY] = irq_summary_out;
    end
  end

  // Read data is loaded as waitrequest falls and held until the next one
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in && avs_waitrequest_out)
      avs_readdata_out <= rdata_next;
  end

  // Stop and software reset are one-cycle commands
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      stop_reg <= 1'b0;
      srst_reg <= 1'b0;
    end
    else
    begin
      stop_reg <= wr_ctrl && wbits[mif_pkg::CTRL_STOP];
      srst_reg <= wr_ctrl && wbits[mif_pkg::CTRL_SW_RST];
    end
  end

  assign soft_kill = stop_reg || srst_reg;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || srst_reg)
      glb_en_reg <= mif_pkg::RST_CLEAR;
    else if (wr_ctrl && be_mask[mif_pkg::CTRL_GLB_EN])
      glb_en_reg <= wbits[mif_pkg::CTRL_GLB_EN];
  end

  // Masks and qualifiers survive stop; only resets touch them
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || srst_reg)
    begin
      rco_mask_reg <= mif_pkg::RST_MASK;
      txb_mask_reg <= mif_pkg::RST_MASK;
      auto_pad_reg <= mif_pkg::RST_CLEAR;
    end
    else if (wr_tfc)
    begin
      if (be_mask[mif_pkg::TFC_RCO_MASK])
        rco_mask_reg <= wbits[mif_pkg::TFC_RCO_MASK];
      if (be_mask[mif_pkg::TFC_TXB_MASK])
        txb_mask_reg <= wbits[mif_pkg::TFC_TXB_MASK];
      if (be_mask[mif_pkg::TFC_AUTO_PAD])
        auto_pad_reg <= wbits[mif_pkg::TFC_AUTO_PAD];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || srst_reg)
    begin
      tok_dis_reg <= mif_pkg::RST_CLEAR;
      lt_en_reg   <= mif_pkg::RST_CLEAR;
    end
    else if (wr_ext)
    begin
      if (be_mask[mif_pkg::EXT_TOK_DIS])
        tok_dis_reg <= wbits[mif_pkg::EXT_TOK_DIS];
      if (be_mask[mif_pkg::EXT_LT_EN])
        lt_en_reg <= wbits[mif_pkg::EXT_LT_EN];
    end
  end

  // A one on the user flag also drops the command, even if set alongside
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || soft_kill)
      user_cmd_reg <= mif_pkg::RST_CLEAR;
    else if (wr_tfc && wbits[mif_pkg::TFC_USER_FLAG])
      user_cmd_reg <= 1'b0;
    else if (wr_tfc && be_mask[mif_pkg::TFC_USER_CMD])
      user_cmd_reg <= wbits[mif_pkg::TFC_USER_CMD];
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      user_set_reg <= 1'b0;
    else
      user_set_reg <= wr_tfc && wbits[mif_pkg::TFC_USER_CMD] &&
                      !wbits[mif_pkg::TFC_USER_FLAG];
  end

  // Done flag: descriptor bit rules when last-tx enable is on
  always_comb
  begin
    done_set = 1'b0;
    if (tx_event_in.done_pulse)
    begin
      if (lt_en_reg)
        done_set = tx_event_in.transmit_descriptor_word_one
                   [mif_pkg::DESC_PER_FRAME_IRQ];
      else
        done_set = !tx_event_in.done_ok || !tok_dis_reg;
    end
  end

  assign flag_set[mif_pkg::FLAG_USER]  = user_set_reg;
  assign flag_set[mif_pkg::FLAG_RCO]   = rx_coll_wrap_in;
  assign flag_set[mif_pkg::FLAG_TXB]   = tx_event_in.begin_pulse;
  assign flag_set[mif_pkg::FLAG_TXD]   = done_set;
  assign flag_clr[mif_pkg::FLAG_USER]  = wr_tfc &&
                                         wbits[mif_pkg::TFC_USER_FLAG];
  assign flag_clr[mif_pkg::FLAG_RCO]   = wr_tfc &&
                                         wbits[mif_pkg::TFC_RCO_FLAG];
  assign flag_clr[mif_pkg::FLAG_TXB]   = wr_tfc &&
                                         wbits[mif_pkg::TFC_TXB_FLAG];
  assign flag_clr[mif_pkg::FLAG_TXD]   = wr_ctrl &&
                                         wbits[mif_pkg::CTRL_TX_DONE];
  assign flag_kill[mif_pkg::FLAG_USER] = soft_kill;
  assign flag_kill[mif_pkg::FLAG_RCO]  = soft_kill;
  assign flag_kill[mif_pkg::FLAG_TXB]  = soft_kill;
  assign flag_kill[mif_pkg::FLAG_TXD]  = soft_kill;

  // Write-one clears the indicators, writes of zero leave them
  genvar gi;
  generate
    for (gi = 0; gi < mif_pkg::FLAG_N; gi++)
    begin : g_flag
      mif_flag_cell u_cell
      (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .set_in   (flag_set[gi]),
        .clear_in (flag_clr[gi]),
        .kill_in  (flag_kill[gi]),
        .flag_out (flags[gi])
      );
    end
  endgenerate

  // Done flag has no mask here; its own enable lives elsewhere
  assign summary_next = user_cmd_reg ||
    (flags[mif_pkg::FLAG_USER]) ||
    (flags[mif_pkg::FLAG_RCO] && !rco_mask_reg) ||
    (flags[mif_pkg::FLAG_TXB] && !txb_mask_reg) ||
    flags[mif_pkg::FLAG_TXD];

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      irq_summary_out    <= 1'b0;
      irq_output_pin_out <= 1'b0;
    end
    else
    begin
      irq_summary_out    <= summary_next;
      irq_output_pin_out <= summary_next && glb_en_reg;
    end
  end

  // Pad and checksum choice latched at frame start
  assign short_frame = tx_event_in.frame_bytes < mif_pkg::MIN_FRAME_BYTES;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      tx_pad_out        <= 1'b0;
      tx_append_fcs_out <= 1'b0;
    end
    else if (tx_event_in.begin_pulse)
    begin
      tx_pad_out        <= auto_pad_reg && short_frame;
      tx_append_fcs_out <= (auto_pad_reg && short_frame) ||
        tx_event_in.transmit_descriptor_word_one
          [mif_pkg::DESC_APPEND_FCS] ||
        !tx_event_in.disable_transmit_checksum;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_user_cmd_write;
    wr_tfc && wbits[mif_pkg::TFC_USER_CMD] && !wbits[mif_pkg::TFC_USER_FLAG];
  endsequence

  sequence s_user_flag_up;
    ##2 flags[mif_pkg::FLAG_USER];
  endsequence

  a_bus_answer: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer not one cycle");

  a_user_cmd_drop: assert property (wr_tfc && wbits[mif_pkg::TFC_USER_FLAG]
    |=> !user_cmd_reg)
    else $error("user flag write left command set");

  a_user_flag_set: assert property (s_user_cmd_write |-> s_user_flag_up)
    else $error("user flag not set after command");

  a_stop_clears: assert property (stop_reg |=> !user_cmd_reg)
    else $error("stop left user command set");

  a_rco_wrap: assert property (rx_coll_wrap_in |=>
    flags[mif_pkg::FLAG_RCO])
    else $error("wrap did not set overflow flag");

  a_rco_irq_gate: assert property (glb_en_reg && !rco_mask_reg &&
    flags[mif_pkg::FLAG_RCO] |=> irq_output_pin_out)
    else $error("unmasked overflow gave no interrupt");

  a_txb_irq_gate: assert property (glb_en_reg && !txb_mask_reg &&
    flags[mif_pkg::FLAG_TXB] |=> irq_output_pin_out)
    else $error("unmasked start gave no interrupt");

  a_irq_off_gate: assert property (!glb_en_reg |=> !irq_output_pin_out)
    else $error("interrupt with global enable low");

  a_w1c_zero: assert property (wr_tfc && !wbits[mif_pkg::TFC_RCO_FLAG] &&
    flags[mif_pkg::FLAG_RCO] && !soft_kill |=> flags[mif_pkg::FLAG_RCO])
    else $error("zero write cleared overflow flag");

  a_mask_reset: assert property ($rose(rst_n_in) |->
    rco_mask_reg && txb_mask_reg)
    else $error("masks not one after reset");

  a_tok_quiet: assert property (tx_event_in.done_pulse &&
    tx_event_in.done_ok && tok_dis_reg && !lt_en_reg &&
    !flags[mif_pkg::FLAG_TXD] |=> !flags[mif_pkg::FLAG_TXD])
    else $error("good frame set done flag while disabled");

  a_lt_force: assert property (tx_event_in.done_pulse && lt_en_reg &&
    tx_event_in.transmit_descriptor_word_one[mif_pkg::DESC_PER_FRAME_IRQ]
    |=> flags[mif_pkg::FLAG_TXD])
    else $error("descriptor request did not set done flag");

  a_pad_short: assert property (tx_event_in.begin_pulse && auto_pad_reg &&
    short_frame |=> tx_pad_out && tx_append_fcs_out)
    else $error("short frame not padded with checksum");

endmodule : mif_top

// ===== verification/mif_top_tb.sv
// Self-checking bench for the MAC interrupt flag block.
// Assumes the Avalon slave answers after one wait cycle, bounded here.
module mif_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk_in;
  logic                   rst_n_in;
  logic [3:0]             avs_address_in;
  logic                   avs_read_in;
  logic                   avs_write_in;
  logic [31:0]            avs_writedata_in;
  logic [3:0]             avs_byteenable_in;
  logic [31:0]            avs_readdata_out;
  logic                   avs_waitrequest_out;
  logic                   rx_coll_wrap_in;
  mif_pkg::mif_tx_event_t tx_event_in;
  logic                   tx_pad_out;
  logic                   tx_append_fcs_out;
  logic                   irq_output_pin_out;
  logic                   irq_summary_out;
  logic [31:0]            rdata;
  int                     failures;
  int                     num_checks;

  mif_top u_mif_top
  (
    .clk_in              (clk_in),
    .rst_n_in            (rst_n_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .rx_coll_wrap_in     (rx_coll_wrap_in),
    .tx_event_in         (tx_event_in),
    .tx_pad_out          (tx_pad_out),
    .tx_append_fcs_out   (tx_append_fcs_out),
    .irq_output_pin_out  (irq_output_pin_out),
    .irq_summary_out     (irq_summary_out)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic conclude;
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_in);
    avs_address_in   <= a;
    avs_write_in     <= w;
    avs_read_in      <= !w;
    avs_writedata_in <= d;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (avs_waitrequest_out !== 1'b0)
    begin
      failures++;
      conclude();
    end
    rdata = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdata, e);
  endtask : rd

  task automatic pin(input logic e, input logic s);
    chk({30'h0, irq_output_pin_out, irq_summary_out}, {30'h0, e, s});
  endtask : pin

  // One-cycle event pulses: collision wrap, frame begin, frame done
  task automatic ev(input logic c, input logic b, input logic d);
    @(posedge clk_in);
    rx_coll_wrap_in        <= c;
    tx_event_in.begin_pulse <= b;
    tx_event_in.done_pulse  <= d;
    @(posedge clk_in);
    rx_coll_wrap_in        <= 1'b0;
    tx_event_in.begin_pulse <= 1'b0;
    tx_event_in.done_pulse  <= 1'b0;
  endtask : ev

  initial
  begin
    failures = 0;
    num_checks = 0;
    rst_n_in = 1'b0;
    avs_address_in = 4'h0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0000_0000;
    avs_byteenable_in = 4'hf;
    rx_coll_wrap_in = 1'b0;
    tx_event_in = '0;
    tx_event_in.frame_bytes = 11'h064;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(4'h0, 32'h0000_0014);
    rd(4'h4, 32'h0000_0000);
    rd(4'hc, 32'h0000_0000);
    wr(4'h8, 32'h0000_0001);
    ev(1'b1, 1'b0, 1'b0);
    rd(4'h0, 32'h0000_0034);
    pin(1'b0, 1'b0);
    // Zeros clear both masks but must leave the flag alone
    wr(4'h0, 32'h0000_0000);
    rd(4'h0, 32'h0000_0020);
    pin(1'b1, 1'b1);
    wr(4'h8, 32'h0000_0000);
    rd(4'h8, 32'h0000_0010);
    pin(1'b0, 1'b1);
    wr(4'h8, 32'h0000_0001);
    wr(4'h0, 32'h0000_0020);
    rd(4'h0, 32'h0000_0000);
    pin(1'b0, 1'b0);
    ev(1'b0, 1'b1, 1'b0);
    rd(4'h0, 32'h0000_0008);
    pin(1'b1, 1'b1);
    // Writing back the value just read clears it
    wr(4'h0, rdata);
    rd(4'h0, 32'h0000_0000);
    wr(4'h0, 32'h0000_0080);
    rd(4'h0, 32'h0000_00c0);
    pin(1'b1, 1'b1);
    wr(4'h0, 32'h0000_00c0);
    rd(4'h0, 32'h0000_0000);
    pin(1'b0, 1'b0);
    wr(4'h0, 32'h0000_0094);
    ev(1'b1, 1'b1, 1'b0);
    wr(4'h4, 32'h0000_c000);
    rd(4'h0, 32'h0000_00fc);
    wr(4'h8, 32'h0000_0003);
    rd(4'h0, 32'h0000_0014);
    rd(4'h4, 32'h0000_c000);
    wr(4'h0, 32'h0000_0800);
    wr(4'h8, 32'h0000_0004);
    rd(4'h0, 32'h0000_0014);
    rd(4'h4, 32'h0000_0000);
    rd(4'h8, 32'h0000_0000);
    // Only the low lane enabled: the pad enable in lane one is kept out
    avs_byteenable_in <= 4'h1;
    wr(4'h0, 32'h0000_0800);
    avs_byteenable_in <= 4'hf;
    rd(4'h0, 32'h0000_0000);
    // Short frame with checksum disabled everywhere else
    wr(4'h0, 32'h0000_0800);
    tx_event_in.disable_transmit_checksum <= 1'b1;
    tx_event_in.frame_bytes <= 11'h03c;
    ev(1'b0, 1'b1, 1'b0);
    @(posedge clk_in);
    chk({30'h0, tx_pad_out, tx_append_fcs_out}, 32'h0000_0003);
    wr(4'h0, 32'h0000_0000);
    ev(1'b0, 1'b1, 1'b0);
    @(posedge clk_in);
    chk({30'h0, tx_pad_out, tx_append_fcs_out}, 32'h0000_0000);
    // Done flag for every mix of qualifiers, request bit and outcome
    for (int i = 0; i < 16; i++)
    begin
      wr(4'h4, {16'h0, i[3], i[2], 14'h0});
      tx_event_in.transmit_descriptor_word_one[28] <= i[1];
      tx_event_in.done_ok <= i[0];
      ev(1'b0, 1'b0, 1'b1);
      bus(1'b0, 4'h8, 32'h0000_0000);
      chk(rdata & 32'h0000_0008,
          (i[2] ? {28'h0, i[1], 3'h0}
                : {28'h0, !i[0] || !i[3], 3'h0}));
      wr(4'h8, 32'h0000_0008);
    end
    conclude();
  end
endmodule : mif_top_tb
